// File: pkg/asfc_defs.vh
// Register offsets, field positions and reset values of the sample buffer
`ifndef ASFC_DEFS_VH
`define ASFC_DEFS_VH

`define ASFC_ADDR_X0        8'h32
`define ASFC_ADDR_X1        8'h33
`define ASFC_ADDR_Y0        8'h34
`define ASFC_ADDR_Y1        8'h35
`define ASFC_ADDR_Z0        8'h36
`define ASFC_ADDR_Z1        8'h37
`define ASFC_ADDR_CTL       8'h38
`define ASFC_ADDR_STAT      8'h39

`define ASFC_CTL_MODE_HI    7
`define ASFC_CTL_MODE_LO    6
`define ASFC_CTL_TRIG_SEL   5
`define ASFC_CTL_CNT_HI     4
`define ASFC_CTL_CNT_LO     0
`define ASFC_STAT_TRIG      7
`define ASFC_STAT_ZERO      6
`define ASFC_STAT_ENT_HI    5
`define ASFC_STAT_ENT_LO    0

`define ASFC_MODE_BYPASS    2'h0
`define ASFC_MODE_FIFO      2'h1
`define ASFC_MODE_STREAM    2'h2
`define ASFC_MODE_TRIGGER   2'h3

`define ASFC_CTL_RESET      8'h00
`define ASFC_RDATA_UNMAPPED 8'h00
`define ASFC_BUF_DEPTH      32
`define ASFC_SAMPLE_WIDTH   48

`endif

// File: logic/asfc_mem.v
// Parameterised sample buffer with registered read data
module asfc_mem #(
	parameter WIDTH = 48,
	parameter DEPTH = 32,
	parameter AW    = 5
) (
	// Clock and reset
	input  wire             core_clk,
	input  wire             rst_n,
	// Filling side
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	// Draining side: a pop request returns data one cycle later
	input  wire             out_ready,
	output reg              out_valid,
	output reg  [WIDTH-1:0] out_data,
	// Fill level
	output reg  [AW:0]      level
);
	reg  [WIDTH-1:0] mem [0:DEPTH-1];
	reg  [AW-1:0]    wr_ptr_reg;
	reg  [AW-1:0]    rd_ptr_reg;
	wire             pop;
	wire             push;

	// A pop in the same cycle frees a slot, so a full buffer can still take data
	assign pop      = out_ready && (level != {(AW+1){1'b0}});
	assign in_ready = (level != DEPTH[AW:0]) || pop;
	assign push     = in_valid && in_ready;

	always @(posedge core_clk) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data;
		end
	end

	always @(posedge core_clk) begin
		if (!rst_n) begin
			wr_ptr_reg <= {AW{1'b0}};
			rd_ptr_reg <= {AW{1'b0}};
			level      <= {(AW+1){1'b0}};
			out_valid  <= 1'b0;
			out_data   <= {WIDTH{1'b0}};
		end else begin
			out_valid <= pop;
			if (pop) begin
				out_data   <= mem[rd_ptr_reg];
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (push && !pop) begin
				level <= level + 1'b1;
			end else if (pop && !push) begin
				level <= level - 1'b1;
			end
		end
	end
endmodule

// File: logic/asfc_top.v
// Three-axis sample buffer control with axis output and status registers
//
// Notes on behaviour
// [RULE1] Trigger source is irq_out_a when select bit is 0, irq_out_b when 1.
// [RULE2] Sample count of zero sets the watermark flag at once, in any mode.
// [RULE3] Host must not program zero sample count in trigger mode.
// [RULE4] Fifo and stream: count is watermark level; bypass ignores it. Code: a zero count still sets the watermark in bypass.
// [RULE5] Trigger mode: count is samples kept from before the trigger.
// [RULE6] Status bit 7 is 1 once a trigger event occurred, else 0.
// [RULE7] Status bits 5..0 give the number of stored entries.
// [RULE8] Oldest buffered sample is presented at the axis output registers.
// [RULE9] Any axis read, single or burst, removes one level.
// [RULE10] Host reads each sample as one burst over all axis bytes.
// [RULE11] Up to 32 stored entries plus one waiting at the output, 33 total.
// [RULE12] Host reads in stream mode or right after new-sample flag rises.
// [RULE13] Low-power mode keeps new-sample flag and buffer working unchanged.
// [RULE14] Control bits 7..6 select bypass, fifo, stream or trigger mode.
// [RULE15] Stream keeps the latest 32 samples, overwriting the oldest.
// [RULE16] Trigger keeps pre-trigger samples, then collects until full.
// [RULE17] Watermark and new-sample flags clear through axis reads.
// [RULE18] Status bit 6 reads zero; writes to status are ignored.
// [RULE19] Fifo mode stops accepting samples at 32 until one is read.
`include "asfc_defs.vh"

module asfc_top #(
	parameter DEPTH = `ASFC_BUF_DEPTH,
	parameter AW    = 5
) (
	// Clock and reset
	input  wire        core_clk,
	input  wire        rst_n,
	// Sample link from the converter, on its own clock
	input  wire        sample_clk,
	input  wire [47:0] sample_data,
	// Interrupt pin levels used as trigger sources
	input  wire        irq_out_a,
	input  wire        irq_out_b,
	// Operating mode
	input  wire        low_power_en,
	// Register port from the serial interface
	input  wire [7:0]  reg_addr,
	input  wire        reg_wr,
	input  wire [7:0]  reg_wdata,
	input  wire        reg_rd,
	input  wire        reg_xfer_end,
	output reg  [7:0]  reg_rdata,
	// Status flags and control register
	output reg         watermark_flag,
	output reg         data_ready_flag,
	output reg         trigger_seen_flag,
	output reg  [7:0]  buffer_control_reg
);
	// Byte of the presented sample for an axis register address
	function [7:0] axis_byte;
		input [47:0] smp;
		input [7:0]  addr;
		begin
			case (addr)
				`ASFC_ADDR_X0: axis_byte = smp[7:0];
				`ASFC_ADDR_X1: axis_byte = smp[15:8];
				`ASFC_ADDR_Y0: axis_byte = smp[23:16];
				`ASFC_ADDR_Y1: axis_byte = smp[31:24];
				`ASFC_ADDR_Z0: axis_byte = smp[39:32];
				`ASFC_ADDR_Z1: axis_byte = smp[47:40];
				default:       axis_byte = `ASFC_RDATA_UNMAPPED;
			endcase
		end
	endfunction

	reg  [2:0]  sclk_sync_reg;
	reg  [47:0] sdata_s1_reg;
	reg  [47:0] sdata_s2_reg;
	reg         trig_prev_reg;
	reg  [47:0] hold_reg;
	reg         hold_valid_reg;
	reg         fetch_busy_reg;
	reg         drop_pend_reg;
	reg         axis_touched_reg;
	wire        sample_tick;
	wire [1:0]  mode;
	wire [4:0]  wm_count;
	wire        trig_src;
	wire        trig_rise;
	wire        host_pop;
	wire        is_axis;
	wire        fifo_in_ready;
	wire        fifo_out_valid;
	wire [47:0] fifo_out_data;
	wire [AW:0] level;
	wire [5:0]  entries;
	wire [7:0]  status_byte;
	wire        at_wm;
	reg         fifo_push;
	reg         drop;
	wire        refill;
	wire        fifo_pop;

	assign mode     = buffer_control_reg[`ASFC_CTL_MODE_HI:`ASFC_CTL_MODE_LO];
	assign wm_count = buffer_control_reg[`ASFC_CTL_CNT_HI:`ASFC_CTL_CNT_LO];
	assign is_axis  = (reg_addr >= `ASFC_ADDR_X0) &&
	                  (reg_addr <= `ASFC_ADDR_Z1);
	assign entries  = level[5:0];
	assign at_wm    = ({1'b0, entries} >= {2'b00, wm_count});

	// Link clock is sampled; data is held stable across its rising edge
	always @(posedge core_clk) begin
		if (!rst_n) begin
			sclk_sync_reg <= 3'h0;
			sdata_s1_reg  <= 48'h000000000000;
			sdata_s2_reg  <= 48'h000000000000;
		end else begin
			sclk_sync_reg <= {sclk_sync_reg[1:0], sample_clk};
			sdata_s1_reg  <= sample_data;
			sdata_s2_reg  <= sdata_s1_reg;
		end
	end
	assign sample_tick = sclk_sync_reg[1] && !sclk_sync_reg[2];

	// [RULE1] trigger source select
	assign trig_src  = buffer_control_reg[`ASFC_CTL_TRIG_SEL] ?
	                   irq_out_b : irq_out_a;
	assign trig_rise = trig_src && !trig_prev_reg &&
	                   (mode == `ASFC_MODE_TRIGGER);

	// [RULE9] one level per host transaction touching axis bytes
	assign host_pop = reg_xfer_end && (axis_touched_reg ||
	                  (reg_rd && is_axis));

	// Buffer admission per mode
	always @* begin
		fifo_push = 1'b0;
		drop      = 1'b0;
		case (mode)
			`ASFC_MODE_BYPASS: begin
				fifo_push = 1'b0;
			end
			`ASFC_MODE_FIFO: begin
				// [RULE19] full buffer refuses via in_ready
				fifo_push = sample_tick;
			end
			`ASFC_MODE_STREAM: begin
				// [RULE15] overwrite oldest when full
				fifo_push = sample_tick;
				drop      = sample_tick && (level == DEPTH[AW:0]);
			end
			`ASFC_MODE_TRIGGER: begin
				fifo_push = sample_tick;
				// [RULE5] keep only wm_count pre-trigger samples
				// [RULE16] after trigger, fill until full
				drop = sample_tick && !trigger_seen_flag && at_wm &&
				       (level != {(AW+1){1'b0}});
			end
			default: begin
				fifo_push = 1'b0;
			end
		endcase
	end

	// Dropping wins the pop port; the refill simply waits a cycle
	assign refill   = !hold_valid_reg && !fetch_busy_reg && !drop &&
	                  (level != {(AW+1){1'b0}}) &&
	                  (mode != `ASFC_MODE_BYPASS);
	assign fifo_pop = drop || refill;

	// [RULE11] 32 stored entries in the buffer
	asfc_mem #(
		.WIDTH (`ASFC_SAMPLE_WIDTH),
		.DEPTH (DEPTH),
		.AW    (AW)
	) u_buf (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.in_valid  (fifo_push),
		.in_ready  (fifo_in_ready),
		.in_data   (sdata_s2_reg),
		.out_ready (fifo_pop),
		.out_valid (fifo_out_valid),
		.out_data  (fifo_out_data),
		.level     (level)
	);

	// [RULE13] low power changes no buffer behaviour
	always @(posedge core_clk) begin
		if (!rst_n) begin
			hold_reg       <= 48'h000000000000;
			hold_valid_reg <= 1'b0;
			fetch_busy_reg <= 1'b0;
			drop_pend_reg  <= 1'b0;
		end else begin
			drop_pend_reg <= drop;
			if (refill) begin
				fetch_busy_reg <= 1'b1;
			end else if (fifo_out_valid && !drop_pend_reg) begin
				fetch_busy_reg <= 1'b0;
			end
			// [RULE8] oldest sample moves to the output holding entry
			if (mode == `ASFC_MODE_BYPASS && sample_tick) begin
				hold_reg       <= sdata_s2_reg;
				hold_valid_reg <= 1'b1;
			end else if (fifo_out_valid && !drop_pend_reg) begin
				hold_reg       <= fifo_out_data;
				hold_valid_reg <= 1'b1;
			end else if (host_pop) begin
				// [RULE17] reading clears the new-sample flag
				hold_valid_reg <= 1'b0;
			end
		end
	end

	// Register port
	always @(posedge core_clk) begin
		if (!rst_n) begin
			buffer_control_reg <= `ASFC_CTL_RESET;
			reg_rdata          <= `ASFC_RDATA_UNMAPPED;
			axis_touched_reg   <= 1'b0;
			trig_prev_reg      <= 1'b0;
			trigger_seen_flag  <= 1'b0;
		end else begin
			trig_prev_reg <= trig_src;
			// [RULE14] mode and count written through the control register
			if (reg_wr && reg_addr == `ASFC_ADDR_CTL) begin
				buffer_control_reg <= reg_wdata;
			end
			// [RULE6] sticky trigger; a new event wins over the clear
			if (trig_rise) begin
				trigger_seen_flag <= 1'b1;
			end else if (reg_wr && reg_addr == `ASFC_ADDR_CTL) begin
				trigger_seen_flag <= 1'b0;
			end
			if (reg_xfer_end) begin
				axis_touched_reg <= 1'b0;
			end else if (reg_rd && is_axis) begin
				axis_touched_reg <= 1'b1;
			end
			if (reg_rd) begin
				if (is_axis) begin
					reg_rdata <= axis_byte(hold_reg, reg_addr);
				end else if (reg_addr == `ASFC_ADDR_CTL) begin
					reg_rdata <= buffer_control_reg;
				end else if (reg_addr == `ASFC_ADDR_STAT) begin
					reg_rdata <= status_byte;
				end else begin
					reg_rdata <= `ASFC_RDATA_UNMAPPED;
				end
			end
		end
	end

	// [RULE7] entry count in low bits
	// [RULE18] bit 6 fixed at zero; status has no write path
	assign status_byte = {trigger_seen_flag, 1'b0, entries};

	always @(posedge core_clk) begin
		if (!rst_n) begin
			watermark_flag  <= 1'b0;
			data_ready_flag <= 1'b0;
		end else begin
			// [RULE2] zero count sets watermark at once
			// [RULE4] entries reaching count, not in bypass
			watermark_flag  <= (wm_count == 5'h00) ||
			                   ((mode != `ASFC_MODE_BYPASS) && at_wm);
			data_ready_flag <= hold_valid_reg;
		end
	end
endmodule

// File: test/asfc_top_props.sv
// Port checks for the sample buffer control
module asfc_top_props (
	// Clock and reset
	input wire       core_clk,
	input wire       rst_n,
	// Trigger pins
	input wire       irq_out_a,
	input wire       irq_out_b,
	// Register port
	input wire [7:0] reg_addr,
	input wire       reg_wr,
	input wire [7:0] reg_wdata,
	input wire       reg_rd,
	input wire       reg_xfer_end,
	input wire [7:0] reg_rdata,
	// Flags and control
	input wire       watermark_flag,
	input wire       data_ready_flag,
	input wire       trigger_seen_flag,
	input wire [7:0] buffer_control_reg
);
	timeunit 1ns;
	timeprecision 1ns;
	logic      axis_reg;
	wire [1:0] mode = buffer_control_reg[7:6];
	wire [4:0] cnt = buffer_control_reg[4:0];
	wire       sel = buffer_control_reg[5];
	wire       trig = mode == 2'h3;
	wire       st_rd = reg_rd && reg_addr == 8'h39;
	wire       ax_rd = reg_rd && reg_addr[7:3] == 5'h06 && reg_addr[2:1] != 2'h0;
	// A pop is owed once the transaction touched the axis bytes
	always @(posedge core_clk)
		if (!rst_n || reg_xfer_end)
			axis_reg <= 1'b0;
		else if (ax_rd)
			axis_reg <= 1'b1;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	zero_count_a: assert property (cnt == 5'h00 |=> watermark_flag)
		else $error("watermark low at zero count");
	bypass_quiet_a: assert property (mode == 2'h0 && cnt != 5'h00
		|=> !watermark_flag) else $error("watermark in bypass");
	trig_first_a: assert property (trig && !sel && $rose(irq_out_a)
		|=> trigger_seen_flag) else $error("first pin event lost");
	trig_second_a: assert property (trig && sel && $rose(irq_out_b)
		|=> trigger_seen_flag) else $error("second pin event lost");
	trig_idle_a: assert property (!trigger_seen_flag &&
		!(trig && $rose(sel ? irq_out_b : irq_out_a)) |=> !trigger_seen_flag)
		else $error("trigger flag without event");
	stat_trig_a: assert property (st_rd && trigger_seen_flag
		|=> reg_rdata[7]) else $error("status trigger bit low");
	stat_bits_a: assert property (st_rd |=> !reg_rdata[6]
		&& reg_rdata[5:0] <= 6'h20) else $error("status field out of range");
	ctl_write_a: assert property (reg_wr && reg_addr == 8'h38
		|=> buffer_control_reg == $past(reg_wdata)) else $error("ctl write");
	pop_level_a: assert property (reg_xfer_end && (axis_reg || ax_rd)
		|-> ##2 !data_ready_flag) else $error("axis read left sample");
	cover property ($rose(trigger_seen_flag));
	cover property (mode == 2'h1 && watermark_flag);
	cover property ($fell(data_ready_flag));
endmodule

// File: test/asfc_host.sv
// Host model driving the register port
module asfc_host (
	// Clock
	input  wire        core_clk,
	// Register port
	output logic [7:0] reg_addr = 8'h00,
	output logic       reg_wr = 1'b0,
	output logic [7:0] reg_wdata = 8'h00,
	output logic       reg_rd = 1'b0,
	output logic       reg_xfer_end = 1'b0,
	input  wire  [7:0] reg_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	task wr(input [7:0] a, input [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
		reg_xfer_end <= 1'b1;
		@(posedge core_clk);
		reg_xfer_end <= 1'b0;
	endtask
	// one burst
	// Each byte lands two edges after its strobe; ending the
	// transaction after the last strobe pops exactly one level
	task rd(input [7:0] a, input int n, output [47:0] q);
		int i;
		q = 48'h0;
		for (i = 0; i <= n + 1; i++) begin
			@(posedge core_clk);
			if (i >= 2)
				q[8*(i-2) +: 8] = reg_rdata;
			reg_rd <= i < n;
			reg_addr <= a + i[7:0];
			reg_xfer_end <= i == n;
		end
	endtask
endmodule

// File: test/asfc_top_test.sv
// Self-checking bench of the sample buffer control
module asfc_top_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic        core_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        sample_clk = 1'b0;
	logic [47:0] sample_data = 48'h0;
	logic        irq_out_a = 1'b0;
	logic        irq_out_b = 1'b0;
	logic        low_power_en = 1'b0;
	logic [47:0] q;
	wire  [7:0]  reg_addr, reg_wdata, reg_rdata, buffer_control_reg;
	wire         reg_wr, reg_rd, reg_xfer_end;
	wire         watermark_flag, data_ready_flag, trigger_seen_flag;
	int          num_errors = 0;
	int          checks_done = 0;
	always #4 core_clk = ~core_clk;
	asfc_top u_asfc_top (.core_clk(core_clk), .rst_n(rst_n),
		.sample_clk(sample_clk), .sample_data(sample_data),
		.irq_out_a(irq_out_a), .irq_out_b(irq_out_b),
		.low_power_en(low_power_en), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_xfer_end(reg_xfer_end),
		.reg_rdata(reg_rdata), .watermark_flag(watermark_flag),
		.data_ready_flag(data_ready_flag),
		.trigger_seen_flag(trigger_seen_flag),
		.buffer_control_reg(buffer_control_reg));
	asfc_host host (.core_clk(core_clk), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
		.reg_xfer_end(reg_xfer_end), .reg_rdata(reg_rdata));
	function [47:0] s(input [7:0] k);
		s = {40'hA55A0FF0C3, k};
	endfunction
	task chk(input [47:0] got, input [47:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: %h not %h", $time, got, exp);
		end
	endtask
	task conclude;
		if (num_errors == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Link clock pulses only while a sample is offered, 80 ns a period
	task push(input [47:0] d);
		sample_data <= d;
		repeat (5) @(posedge core_clk);
		sample_clk <= 1'b1;
		repeat (5) @(posedge core_clk);
		sample_clk <= 1'b0;
	endtask
	task pin(input b);
		irq_out_a <= !b;
		irq_out_b <= b;
		repeat (2) @(posedge core_clk);
		irq_out_a <= 1'b0;
		irq_out_b <= 1'b0;
		repeat (2) @(posedge core_clk);
	endtask
	task get;
		int n;
		for (n = 0; data_ready_flag !== 1'b1; n++) begin
			if (n == 20) begin
				num_errors++;
				conclude;
			end
			@(posedge core_clk);
		end
		host.rd(8'h32, 6, q);
		repeat (4) @(posedge core_clk);
	endtask
	task drain;
		int n;
		for (n = 0; data_ready_flag === 1'b1 && n < 40; n++)
			get;
		chk(data_ready_flag, 1'b0);
	endtask
	task t_idle;
		chk(watermark_flag, 1'b1);
		host.wr(8'h39, 8'hFF);
		host.wr(8'h33, 8'hFF);
		host.rd(8'h39, 1, q);
		chk(q[7:0], 8'h00);
		chk(buffer_control_reg, 8'h00);
		host.rd(8'h3A, 1, q);
		chk(q[7:0], 8'h00);
	endtask
	task t_bypass;
		host.wr(8'h38, 8'h05);
		push(s(8'h01));
		push(s(8'h02));
		chk(watermark_flag, 1'b0);
		get;
		chk(q, s(8'h02));
	endtask
	task t_fifo;
		int k;
		low_power_en <= 1'b1;
		host.wr(8'h38, 8'h44);
		for (k = 0; k < 34; k++)
			push(s(k[7:0]));
		host.rd(8'h39, 1, q);
		chk(q[7:0], 8'h20);
		chk(watermark_flag, 1'b1);
		get;
		chk(q, s(8'h00));
		host.rd(8'h32, 1, q);
		chk(q[7:0], 8'h01);
		host.rd(8'h39, 1, q);
		chk(q[7:0], 8'h1E);
		for (k = 2; k < 33; k++) begin
			get;
			chk(q, s(k[7:0]));
		end
		chk(data_ready_flag, 1'b0);
		chk(watermark_flag, 1'b0);
	endtask
	task t_stream;
		int k;
		host.wr(8'h38, 8'h80);
		for (k = 0; k < 34; k++)
			push(s(k[7:0]));
		chk(watermark_flag, 1'b1);
		get;
		chk(q, s(8'h00));
		get;
		chk(q, s(8'h02));
		drain;
	endtask
	task t_trig;
		int k;
		host.wr(8'h38, 8'hE3);
		for (k = 0; k < 6; k++)
			push(s(k[7:0]));
		pin(1'b0);
		chk(trigger_seen_flag, 1'b0);
		pin(1'b1);
		chk(trigger_seen_flag, 1'b1);
		host.rd(8'h39, 1, q);
		chk(q[7:0], 8'h83);
		push(s(8'h06));
		push(s(8'h07));
		host.rd(8'h39, 1, q);
		chk(q[7:0], 8'h85);
		get;
		chk(q, s(8'h00));
		get;
		chk(q, s(8'h03));
		drain;
		// First pin as trigger source, second pin ignored
		host.wr(8'h38, 8'hC3);
		host.rd(8'h38, 1, q);
		chk(q[7:0], 8'hC3);
		chk(trigger_seen_flag, 1'b0);
		pin(1'b1);
		chk(trigger_seen_flag, 1'b0);
		pin(1'b0);
		chk(trigger_seen_flag, 1'b1);
		host.wr(8'h38, 8'h00);
		host.rd(8'h39, 1, q);
		chk(q[7:0], 8'h00);
	endtask
	initial begin
		repeat (16) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge core_clk);
		t_idle;
		t_bypass;
		t_fifo;
		t_stream;
		t_trig;
		conclude;
	end
endmodule
bind asfc_top asfc_top_props u_props (.core_clk(core_clk), .rst_n(rst_n),
	.irq_out_a(irq_out_a), .irq_out_b(irq_out_b), .reg_addr(reg_addr),
	.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
	.reg_xfer_end(reg_xfer_end), .reg_rdata(reg_rdata),
	.watermark_flag(watermark_flag), .data_ready_flag(data_ready_flag),
	.trigger_seen_flag(trigger_seen_flag),
	.buffer_control_reg(buffer_control_reg));
